// ===== include/tcf_params.svh
// constants for the tape coupler: register map, field positions, timings
// assumes a 32-bit AHB-Lite slave with word-aligned registers
`ifndef TCF_PARAMS_SVH
`define TCF_PARAMS_SVH
// printed register offsets are even, not all multiples of four: indexes
`define TCF_IDX_STATUS 8'h50
`define TCF_IDX_CMD 8'h51
`define TCF_IDX_BRC 8'h52
`define TCF_IDX_CMA 8'h53
`define TCF_IDX_DATA 8'h54
`define TCF_IDX_RDLN 8'h55
`define TCF_ADDR_STATUS 12'h140
`define TCF_ADDR_CMD 12'h144
`define TCF_ADDR_BRC 12'h148
`define TCF_ADDR_CMA 12'h14C
`define TCF_ADDR_DATA 12'h150
`define TCF_ADDR_RDLN 12'h154
`define TCF_ADDR_IRQ_STAT 12'h180
`define TCF_ADDR_IRQ_EN 12'h184
`define TCF_ADDR_IRQ_CLR 12'h188
`define TCF_ADDR_CTRL 12'h18C
`define TCF_VECTOR 9'h094
// command register fields
`define TCF_CMD_GO 0
`define TCF_CMD_FN_LO 1
`define TCF_CMD_UNIT_LO 8
`define TCF_CMD_DEN 13
// control register fields
`define TCF_CTRL_INIT 0
`define TCF_CTRL_7TRK 1
// irq bits
`define TCF_IRQ_DONE 0
`define TCF_IRQ_ERR 1
`define TCF_IRQ_ST_FAIL 2
// self test length and pattern
`define TCF_ST_CYCLES 16'd64
`define TCF_ST_PATTERN 16'hA5C3
`endif

// ===== include/tcf_pkg.sv
// types for the tape coupler
// assumes tcf_params.svh for numeric constants
package tcf_pkg;
	typedef enum logic [2:0] {
		TCF_FN_READ = 3'h0,
		TCF_FN_WRITE = 3'h1,
		TCF_FN_WEOF = 3'h2,
		TCF_FN_SPFWD = 3'h3,
		TCF_FN_SPREV = 3'h4,
		TCF_FN_ERASE = 3'h5,
		TCF_FN_REWIND = 3'h6,
		TCF_FN_NOP = 3'h7
	} tcf_fn_e;
	typedef enum logic [3:0] {
		TCF_ST_TEST = 4'h0,
		TCF_ST_IDLE = 4'h1,
		TCF_ST_ISSUE = 4'h2,
		TCF_ST_WAITBSY = 4'h3,
		TCF_ST_XFER = 4'h4,
		TCF_ST_DMA = 4'h5,
		TCF_ST_WAITEND = 4'h6,
		TCF_ST_CHAIN = 4'h7,
		TCF_ST_DONE = 4'h8
	} tcf_state_e;
endpackage

// ===== tb/tape_coupler_host_formatter_test.sv
// self-checking bench for the tape coupler: bus tasks, dma memory, formatter
// assumes tcf_coupler and tcf_fmt_model are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "tcf_params.svh"
`define CHK(a, e) chk(32'(a), 32'(e))
`define WAITFOR(c, n) for (k = 0; k < n; k++) begin @(posedge hclk); \
	if (c) break; end if (k == n) tmo
module tape_coupler_host_formatter_test;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd, got;
	logic dma_req, dma_wr, dma_ack, irq, irq_grant, inj_err, saw_dled;
	logic [15:0] dma_addr, dma_wdata, dma_rdata, exp_addr;
	logic [8:0] irq_vector;
	logic initiate_command_line, reverse_direction_line, rewind_line;
	logic write_read_select, write_file_mark_line, erase_line, edit_line;
	logic transport_select_0, transport_select_1, formatter_select_line;
	logic density_select_line, parity_select_line, last_word_line;
	logic [7:0] write_data, read_data;
	logic formatter_busy_line, data_busy_line, write_demand_strobe;
	logic read_byte_strobe, hard_error_line, corrected_error_line;
	logic file_mark_seen_line, end_of_tape_line, load_point_line;
	logic rewinding_line, file_protect_line, on_line_line;
	logic byte_order_jumper, diag_pass_led, busy_led, dma_led, moved;
	logic [4:0] sel;
	int n_mismatch = 0, compares = 0, k, j;
	// rows: register, word written, word read back
	logic [11:0] r_addr [5] = '{`TCF_ADDR_BRC, `TCF_ADDR_CMA, 12'h1F0,
		`TCF_ADDR_IRQ_STAT, `TCF_ADDR_IRQ_EN};
	logic [31:0] r_wr [5] = '{32'h1234, 32'h0120, 32'hFFFF, 32'h7, 32'h1};
	logic [31:0] r_exp [5] = '{32'h1234, 32'h0120, 32'h0, 32'h0, 32'h1};
	assign hready = hreadyout;
	tcf_coupler u_tcf_coupler (.*);
	tcf_fmt_model u_tcf_fmt_model (.*);
	task chk(input logic [31:0] a, input logic [31:0] e);
		compares++;
		if (a !== e) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, a, e);
		end
	endtask
	task test_done;
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task tmo;
		n_mismatch++;
		test_done;
	endtask
	task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		`WAITFOR(hready === 1'b1, 50);
		htrans <= 2'h0;
		hwdata <= d;
		`WAITFOR(hready === 1'b1, 50);
		rd = hrdata;
	endtask
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	initial begin
		repeat (60000) @(posedge hclk);
		tmo;
	end
	// host memory: answers each word request at once, then pauses two cycles
	initial begin
		dma_ack = 1'b0;
		dma_rdata = 16'h0;
		forever begin
			@(posedge hclk);
			if (dma_req === 1'b1) begin
				`CHK(dma_wr, 1'b0);
				`CHK(dma_addr, exp_addr);
				exp_addr = exp_addr + 16'h2;
				dma_rdata <= {~dma_addr[7:0], dma_addr[7:0]};
				dma_ack <= 1'b1;
				@(posedge hclk);
				saw_dled = saw_dled | dma_led;
				dma_ack <= 1'b0;
				repeat (2) @(posedge hclk);
			end
		end
	end
	initial begin
		{hresetn, hsel, hwrite, irq_grant, inj_err, saw_dled} = '0;
		{haddr, htrans, hsize, hwdata, exp_addr} = '0;
		byte_order_jumper = 1'b1;
		repeat (4) @(posedge hclk);
		`CHK(diag_pass_led, 1'b0);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		`CHK(busy_led, 1'b1);
		`CHK(diag_pass_led, 1'b0);
		`WAITFOR(diag_pass_led === 1'b1, 400);
		ahb(1'b0, `TCF_ADDR_STATUS, 32'h0);
		`CHK(rd & 32'h6, 32'h6);
		$display("test reset done");
		for (j = 0; j < 5; j++) begin
			ahb(1'b1, r_addr[j], r_wr[j]);
			ahb(1'b0, r_addr[j], 32'h0);
			`CHK(rd, r_exp[j]);
		end
		$display("test registers done");
		ahb(1'b1, `TCF_ADDR_CTRL, 32'h2);
		repeat (2) @(posedge hclk);
		`CHK(parity_select_line, 1'b1);
		ahb(1'b1, `TCF_ADDR_CTRL, 32'h0);
		repeat (2) @(posedge hclk);
		`CHK(parity_select_line, 1'b0);
		$display("test parity done");
		// jumper fitted and clean, then removed with a hard error
		for (j = 1; j >= 0; j--) begin
			byte_order_jumper <= j[0];
			inj_err <= !j[0];
			exp_addr = 16'h0120;
			saw_dled = 1'b0;
			ahb(1'b1, `TCF_ADDR_CMA, 32'h0120);
			ahb(1'b1, `TCF_ADDR_BRC, 32'hFFFC);
			ahb(1'b1, `TCF_ADDR_CMD, 32'h2503);
			`WAITFOR(irq === 1'b1, 2000);
			`WAITFOR(formatter_busy_line === 1'b0, 400);
			`CHK(got, j ? 32'h20DF22DD : 32'hDF20DD22);
			`CHK(sel, 5'h1B);
			`CHK(moved, 1'b0);
			`CHK(saw_dled, 1'b1);
			`CHK(exp_addr, 16'h0124);
			ahb(1'b0, `TCF_ADDR_IRQ_STAT, 32'h0);
			`CHK(rd, j ? 32'h1 : 32'h3);
			ahb(1'b1, `TCF_ADDR_IRQ_EN, 32'h0);
			repeat (2) @(posedge hclk);
			`CHK(irq, 1'b0);
			ahb(1'b1, `TCF_ADDR_IRQ_EN, 32'h1);
			repeat (2) @(posedge hclk);
			`CHK(irq, 1'b1);
			irq_grant <= 1'b1;
			repeat (2) @(posedge hclk);
			`CHK(irq_vector, `TCF_VECTOR);
			irq_grant <= 1'b0;
			ahb(1'b1, `TCF_ADDR_IRQ_CLR, 32'h3);
			repeat (2) @(posedge hclk);
			`CHK(irq, 1'b0);
			ahb(1'b0, `TCF_ADDR_IRQ_STAT, 32'h0);
			`CHK(rd, 32'h0);
			$display("test write transfer done");
		end
		ahb(1'b1, `TCF_ADDR_CTRL, 32'h1);
		repeat (3) @(posedge hclk);
		`CHK(busy_led, 1'b1);
		`CHK(diag_pass_led, 1'b0);
		`WAITFOR(diag_pass_led === 1'b1, 400);
		$display("test initialise done");
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		`CHK(diag_pass_led, 1'b0);
		hresetn <= 1'b1;
		`WAITFOR(diag_pass_led === 1'b1, 400);
		$display("test second reset done");
		test_done;
	end
endmodule
`default_nettype wire

// ===== tb/tcf_fmt_model.sv
// formatter model for the tape coupler bench: busy, demand strobes, capture
// assumes the coupler's formatter port names and one clock hclk
`timescale 1ns/100ps
`default_nettype none
module tcf_fmt_model (
	// clock and test controls
	input wire logic hclk,
	input wire logic inj_err,
	// lines from the coupler
	input wire logic initiate_command_line, reverse_direction_line,
	input wire logic rewind_line, write_read_select, write_file_mark_line,
	input wire logic erase_line, transport_select_0, transport_select_1,
	input wire logic formatter_select_line, density_select_line,
	input wire logic [7:0] write_data,
	// lines to the coupler
	output logic formatter_busy_line, data_busy_line, hard_error_line,
	output logic write_demand_strobe, read_byte_strobe,
	output logic [7:0] read_data,
	output logic corrected_error_line, file_mark_seen_line, end_of_tape_line,
	output logic load_point_line, rewinding_line, file_protect_line,
	output logic on_line_line,
	// observations for the bench
	output logic [31:0] got,
	output logic [4:0] sel,
	output logic moved
);
	logic [4:0] ctl;
	int i;
	// drive on line at load point, otherwise quiet
	assign {corrected_error_line, file_mark_seen_line, end_of_tape_line,
		load_point_line, rewinding_line, file_protect_line,
		on_line_line} = 7'h09;
	// undriven read lines churn so a stale byte is never mistaken for data
	always @(posedge hclk) read_data <= ~read_data;
	always @(posedge hclk) begin
		if (initiate_command_line === 1'b1 && formatter_busy_line &&
			{reverse_direction_line, rewind_line, write_file_mark_line,
			erase_line, write_read_select} !== ctl) begin
			moved <= 1'b1;
		end
	end
	initial begin
		{formatter_busy_line, data_busy_line, hard_error_line} = 3'h0;
		{write_demand_strobe, read_byte_strobe} = 2'h0;
		{got, sel, moved, ctl} = '0;
		read_data = 8'h5A;
		forever begin
			@(posedge hclk);
			if (initiate_command_line === 1'b1 && !formatter_busy_line) begin
				ctl <= {reverse_direction_line, rewind_line,
					write_file_mark_line, erase_line, write_read_select};
				sel <= {density_select_line, formatter_select_line,
					transport_select_1, transport_select_0, write_read_select};
				repeat (3) @(posedge hclk);
				formatter_busy_line <= 1'b1;
				data_busy_line <= 1'b1;
				hard_error_line <= inj_err;
				for (i = 0; i < 4 && write_read_select; i++) begin
					// give the coupler time to fetch the word before demanding
					repeat (16) @(posedge hclk);
					write_demand_strobe <= 1'b1;
					repeat (3) @(posedge hclk);
					write_demand_strobe <= 1'b0;
					repeat (6) @(posedge hclk);
					got <= {got[23:0], write_data};
				end
				repeat (4) @(posedge hclk);
				{formatter_busy_line, data_busy_line, hard_error_line} <= 3'h0;
			end
		end
	end
endmodule
`default_nettype wire

// ===== verilog/tcf_coupler.sv
// tape coupler: AHB-Lite registers, command sequencer, formatter link, dma
// assumes formatter pins arrive asynchronous; dma master handshake on hclk
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "tcf_params.svh"
// Notes on behaviour
// - self test runs after reset and after a software initialise.
// - pass indicator lights only after a successful self test.
// - busy and dma-active indicators are driven while running.
// - data moves as 16-bit words by dma; commands via registers.
// - fixed interrupt vector 224 presented with the interrupt grant.
// - interrupt on operation done, on a hard error while a command runs, and on a failed self test.
// - each command becomes one or an ordered string of formatter commands.
// - data words are held and interlocked so none is lost.
// - unit number selects formatter and transport, eight drives.
// - jumper fitted: low byte first; removed: high byte first.
// - write bytes go out on eight lines, one per demand strobe.
// - parity select stays low unless seven-track mode is set.
// - six word registers at consecutive indexes from the status one.
module tcf_coupler import tcf_pkg::*; (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// dma word port to host memory
	output logic dma_req,
	output logic dma_wr,
	output logic [15:0] dma_addr,
	output logic [15:0] dma_wdata,
	input wire logic [15:0] dma_rdata,
	input wire logic dma_ack,
	// host interrupt
	output logic irq,
	input wire logic irq_grant,
	output logic [8:0] irq_vector,
	// formatter link
	output logic initiate_command_line,
	output logic reverse_direction_line,
	output logic rewind_line,
	output logic write_read_select,
	output logic write_file_mark_line,
	output logic erase_line,
	output logic edit_line,
	output logic transport_select_0,
	output logic transport_select_1,
	output logic formatter_select_line,
	output logic density_select_line,
	output logic parity_select_line,
	output logic last_word_line,
	output logic [7:0] write_data,
	input wire logic formatter_busy_line,
	input wire logic data_busy_line,
	input wire logic write_demand_strobe,
	input wire logic read_byte_strobe,
	input wire logic [7:0] read_data,
	input wire logic hard_error_line,
	input wire logic corrected_error_line,
	input wire logic file_mark_seen_line,
	input wire logic end_of_tape_line,
	input wire logic load_point_line,
	input wire logic rewinding_line,
	input wire logic file_protect_line,
	input wire logic on_line_line,
	input wire logic byte_order_jumper,
	// indicators
	output logic diag_pass_led,
	output logic busy_led,
	output logic dma_led
);
	localparam int NS = 14;
	// two-stage synchronisers for every formatter input
	logic [NS-1:0] sy1_ff, sy2_ff, sy3_ff;
	wire logic [NS-1:0] pins = {formatter_busy_line, data_busy_line,
		write_demand_strobe, read_byte_strobe, hard_error_line,
		corrected_error_line, file_mark_seen_line, end_of_tape_line,
		load_point_line, rewinding_line, file_protect_line, on_line_line,
		byte_order_jumper, 1'b0};
	logic [7:0] rd1_ff, rd2_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sy1_ff <= '0;
			sy2_ff <= '0;
			sy3_ff <= '0;
			rd1_ff <= 8'h00;
			rd2_ff <= 8'h00;
		end else begin
			sy1_ff <= pins;
			sy2_ff <= sy1_ff;
			sy3_ff <= sy2_ff;
			rd1_ff <= read_data;
			rd2_ff <= rd1_ff;
		end
	end
	wire logic f_busy = sy2_ff[13];
	wire logic d_busy = sy2_ff[12];
	wire logic dem_rise = sy2_ff[11] & ~sy3_ff[11];
	wire logic rstr_rise = sy2_ff[10] & ~sy3_ff[10];
	wire logic hard_err = sy2_ff[9];
	wire logic low_first = sy2_ff[1];
	wire logic [15:0] tape_status = {sy2_ff[9:2], 8'h00};

	// ahb address phase capture
	logic ap_wr_ff;
	logic [11:0] ap_addr_ff;
	wire logic ap_take = hsel & hready & htrans[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_ff <= 1'b0;
			ap_addr_ff <= 12'h000;
		end else begin
			ap_wr_ff <= ap_take & hwrite;
			ap_addr_ff <= haddr;
		end
	end
	wire logic wr_cmd = ap_wr_ff && ap_addr_ff == `TCF_ADDR_CMD;

	// registers and sequencer
	tcf_state_e st_ff, nxt_st;
	logic [15:0] cmd_ff, nxt_cmd, brc_ff, nxt_brc, cma_ff, nxt_cma;
	logic [15:0] dbuf_ff, nxt_dbuf, tcnt_ff, nxt_tcnt;
	logic [2:0] ist_ff, nxt_ist, ien_ff, nxt_ien;
	logic [1:0] ctrl_ff, nxt_ctrl;
	logic full_ff, nxt_full, hi_ff, nxt_hi, pass_ff, nxt_pass;
	logic go_ff, nxt_go, dreq_ff, nxt_dreq, wrsel_ff, nxt_wrsel;
	logic [7:0] wd_ff, nxt_wd;
	logic [2:0] fn_ff, nxt_fn;
	logic [31:0] rdata_ff, nxt_rdata;

	always_comb begin
		nxt_st = st_ff;
		nxt_cmd = cmd_ff;
		nxt_brc = brc_ff;
		nxt_cma = cma_ff;
		nxt_dbuf = dbuf_ff;
		nxt_tcnt = tcnt_ff;
		nxt_ist = ist_ff;
		nxt_ien = ien_ff;
		nxt_ctrl = ctrl_ff;
		nxt_full = full_ff;
		nxt_hi = hi_ff;
		nxt_pass = pass_ff;
		nxt_go = go_ff;
		nxt_dreq = dreq_ff;
		nxt_wrsel = wrsel_ff;
		nxt_wd = wd_ff;
		nxt_fn = fn_ff;
		nxt_rdata = 32'h0000_0000;
		if (ap_wr_ff) begin
			case (ap_addr_ff)
				`TCF_ADDR_CMD: nxt_cmd = hwdata[15:0];
				`TCF_ADDR_BRC: nxt_brc = hwdata[15:0];
				`TCF_ADDR_CMA: nxt_cma = hwdata[15:0];
				`TCF_ADDR_DATA: nxt_dbuf = hwdata[15:0];
				`TCF_ADDR_IRQ_EN: nxt_ien = hwdata[2:0];
				`TCF_ADDR_IRQ_CLR: nxt_ist = ist_ff & ~hwdata[2:0];
				`TCF_ADDR_CTRL: nxt_ctrl = hwdata[1:0];
				default: ;
			endcase
		end
		// decoded in the address phase so hrdata stands in the data phase
		if (ap_take && !hwrite) begin
			case (haddr)
				`TCF_ADDR_STATUS: nxt_rdata = {16'h0000, tape_status[15:8],
					3'h0, full_ff, 1'b0, pass_ff, st_ff == TCF_ST_IDLE,
					dreq_ff};
				`TCF_ADDR_CMD: nxt_rdata = {16'h0000, cmd_ff};
				`TCF_ADDR_BRC: nxt_rdata = {16'h0000, brc_ff};
				`TCF_ADDR_CMA: nxt_rdata = {16'h0000, cma_ff};
				`TCF_ADDR_DATA: nxt_rdata = {16'h0000, dbuf_ff};
				`TCF_ADDR_RDLN: nxt_rdata = {24'h000000, rd2_ff};
				`TCF_ADDR_IRQ_STAT: nxt_rdata = {29'h0, ist_ff};
				`TCF_ADDR_IRQ_EN: nxt_rdata = {29'h0, ien_ff};
				`TCF_ADDR_CTRL: nxt_rdata = {30'h0, ctrl_ff};
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
		case (st_ff)
			TCF_ST_TEST: begin
				nxt_tcnt = tcnt_ff + 16'd1;
				nxt_dbuf = dbuf_ff ^ `TCF_ST_PATTERN;
				if (tcnt_ff == `TCF_ST_CYCLES) begin
					nxt_pass = dbuf_ff == 16'h0000;
					if (dbuf_ff != 16'h0000)
						nxt_ist[`TCF_IRQ_ST_FAIL] = 1'b1;
					nxt_st = TCF_ST_IDLE;
				end
			end
			TCF_ST_IDLE: begin
				if (wr_cmd && hwdata[`TCF_CMD_GO]) begin
					nxt_fn = hwdata[`TCF_CMD_FN_LO +: 3];
					nxt_full = 1'b0;
					nxt_hi = 1'b0;
					nxt_wrsel = hwdata[`TCF_CMD_FN_LO +: 3] == TCF_FN_WRITE
						|| hwdata[`TCF_CMD_FN_LO +: 3] == TCF_FN_WEOF
						|| hwdata[`TCF_CMD_FN_LO +: 3] == TCF_FN_ERASE;
					nxt_st = TCF_ST_ISSUE;
				end
			end
			TCF_ST_ISSUE: if (!f_busy) begin
				nxt_go = 1'b1;
				nxt_st = TCF_ST_WAITBSY;
			end
			TCF_ST_WAITBSY: if (f_busy) begin
				nxt_go = 1'b0;
				nxt_st = (fn_ff == TCF_FN_READ || fn_ff == TCF_FN_WRITE)
					? TCF_ST_XFER : TCF_ST_WAITEND;
			end
			TCF_ST_XFER: begin
				if (fn_ff == TCF_FN_WRITE && !full_ff && !dreq_ff
					&& brc_ff != 16'h0000) begin
					nxt_dreq = 1'b1;
					nxt_st = TCF_ST_DMA;
				end else if (fn_ff == TCF_FN_WRITE && dem_rise && full_ff) begin
					nxt_wd = (low_first ^ hi_ff) ? dbuf_ff[7:0] : dbuf_ff[15:8];
					nxt_hi = ~hi_ff;
					if (hi_ff) begin
						nxt_full = 1'b0;
						nxt_brc = brc_ff + 16'd2;
					end
				end else if (fn_ff == TCF_FN_READ && rstr_rise) begin
					if (low_first ^ hi_ff)
						nxt_dbuf[7:0] = rd2_ff;
					else
						nxt_dbuf[15:8] = rd2_ff;
					nxt_hi = ~hi_ff;
					if (hi_ff) begin
						nxt_dreq = 1'b1;
						nxt_brc = brc_ff + 16'd2;
						nxt_st = TCF_ST_DMA;
					end
				end else if (!d_busy && !f_busy) begin
					nxt_st = TCF_ST_DONE;
				end
				if (brc_ff == 16'h0000 && fn_ff == TCF_FN_WRITE && !full_ff)
					nxt_st = TCF_ST_WAITEND;
			end
			TCF_ST_DMA: if (dma_ack) begin
				nxt_dreq = 1'b0;
				nxt_cma = cma_ff + 16'd2;
				if (fn_ff == TCF_FN_WRITE) begin
					nxt_dbuf = dma_rdata;
					nxt_full = 1'b1;
				end
				nxt_st = TCF_ST_XFER;
			end
			TCF_ST_WAITEND: if (!f_busy)
				nxt_st = fn_ff == TCF_FN_ERASE ? TCF_ST_CHAIN : TCF_ST_DONE;
			TCF_ST_CHAIN: begin
				nxt_fn = TCF_FN_WEOF;
				nxt_st = TCF_ST_ISSUE;
			end
			TCF_ST_DONE: begin
				nxt_ist[`TCF_IRQ_DONE] = 1'b1;
				if (hard_err)
					nxt_ist[`TCF_IRQ_ERR] = 1'b1;
				nxt_st = TCF_ST_IDLE;
			end
			default: nxt_st = TCF_ST_IDLE;
		endcase
		if (hard_err && st_ff != TCF_ST_IDLE && st_ff != TCF_ST_TEST)
			nxt_ist[`TCF_IRQ_ERR] = 1'b1;
		if (ap_wr_ff && ap_addr_ff == `TCF_ADDR_CTRL
			&& hwdata[`TCF_CTRL_INIT]) begin
			nxt_st = TCF_ST_TEST;
			nxt_tcnt = 16'h0000;
			nxt_dbuf = 16'h0000;
			nxt_pass = 1'b0;
			nxt_go = 1'b0;
			nxt_dreq = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= TCF_ST_TEST;
			cmd_ff <= 16'h0000;
			brc_ff <= 16'h0000;
			cma_ff <= 16'h0000;
			dbuf_ff <= 16'h0000;
			tcnt_ff <= 16'h0000;
			ist_ff <= 3'h0;
			ien_ff <= 3'h0;
			ctrl_ff <= 2'h0;
			full_ff <= 1'b0;
			hi_ff <= 1'b0;
			pass_ff <= 1'b0;
			go_ff <= 1'b0;
			dreq_ff <= 1'b0;
			wrsel_ff <= 1'b0;
			wd_ff <= 8'h00;
			fn_ff <= 3'h7;
			rdata_ff <= 32'h0000_0000;
		end else begin
			st_ff <= nxt_st;
			cmd_ff <= nxt_cmd;
			brc_ff <= nxt_brc;
			cma_ff <= nxt_cma;
			dbuf_ff <= nxt_dbuf;
			tcnt_ff <= nxt_tcnt;
			ist_ff <= nxt_ist;
			ien_ff <= nxt_ien;
			ctrl_ff <= nxt_ctrl;
			full_ff <= nxt_full;
			hi_ff <= nxt_hi;
			pass_ff <= nxt_pass;
			go_ff <= nxt_go;
			dreq_ff <= nxt_dreq;
			wrsel_ff <= nxt_wrsel;
			wd_ff <= nxt_wd;
			fn_ff <= nxt_fn;
			rdata_ff <= nxt_rdata;
		end
	end

	// output flops for interrupt, vector and indicators
	logic irq_ff, busy_ff, dled_ff, vec_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_ff <= 1'b0;
			busy_ff <= 1'b0;
			dled_ff <= 1'b0;
			vec_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_ist & nxt_ien);
			busy_ff <= nxt_st != TCF_ST_IDLE;
			dled_ff <= nxt_dreq;
			vec_ff <= irq_grant & irq_ff;
		end
	end
	assign irq = irq_ff;
	assign irq_vector = vec_ff ? `TCF_VECTOR : 9'h000;
	assign busy_led = busy_ff;
	assign dma_led = dled_ff;
	assign diag_pass_led = pass_ff;
	assign hrdata = rdata_ff;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign dma_req = dreq_ff;
	assign dma_wr = ~wrsel_ff;
	assign dma_addr = cma_ff;
	assign dma_wdata = dbuf_ff;
	// control lines come from the command register, steady through the op
	assign initiate_command_line = go_ff;
	assign reverse_direction_line = fn_ff == TCF_FN_SPREV;
	assign rewind_line = fn_ff == TCF_FN_REWIND;
	assign write_read_select = wrsel_ff;
	assign write_file_mark_line = fn_ff == TCF_FN_WEOF;
	assign erase_line = fn_ff == TCF_FN_ERASE;
	assign edit_line = 1'b0;
	assign transport_select_0 = cmd_ff[`TCF_CMD_UNIT_LO];
	assign transport_select_1 = cmd_ff[`TCF_CMD_UNIT_LO + 1];
	assign formatter_select_line = cmd_ff[`TCF_CMD_UNIT_LO + 2];
	assign density_select_line = cmd_ff[`TCF_CMD_DEN];
	assign parity_select_line = ctrl_ff[`TCF_CTRL_7TRK];
	assign last_word_line = full_ff && brc_ff == 16'hFFFE;
	assign write_data = wd_ff;

	a_go_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(go_ff) |-> $past(!f_busy)) else $error("go while busy");
	a_irq_cause: assert property (@(posedge hclk) disable iff (!hresetn)
		irq |-> $past(|(ist_ff & ien_ff)) || $past(|(nxt_ist & nxt_ien)))
		else $error("irq without cause");
	a_par_gnd: assert property (@(posedge hclk) disable iff (!hresetn)
		!ctrl_ff[`TCF_CTRL_7TRK] |-> !parity_select_line)
		else $error("parity select driven");
	a_pass_test: assert property (@(posedge hclk) disable iff (!hresetn)
		st_ff == TCF_ST_TEST |-> !diag_pass_led)
		else $error("pass lit during test");
	a_vec_value: assert property (@(posedge hclk) disable iff (!hresetn)
		irq_grant && irq |=> irq_vector == `TCF_VECTOR)
		else $error("bad vector");
	a_dma_led: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(dma_req) |-> dma_led) else $error("dma led off");
	a_busy_led: assert property (@(posedge hclk) disable iff (!hresetn)
		st_ff == TCF_ST_XFER |-> ##1 busy_led)
		else $error("busy led off");
	a_cma_step: assert property (@(posedge hclk) disable iff (!hresetn)
		st_ff == TCF_ST_DMA && dma_ack && !ap_wr_ff |=>
		cma_ff == $past(cma_ff) + 16'd2) else $error("address step");
endmodule
`default_nettype wire
